// file: dcs_consts.svh
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

// ==========================================================================
// Host datagram decode.
// ==========================================================================
`define DCS_GLOBAL_ABS_ADDR 8'h7E
`define DCS_RW_BIT 24
`define DCS_ADDR_MSB 31
`define DCS_ADDR_LSB 25

// ==========================================================================
// Field positions inside the global parameter data word.
// ==========================================================================
`define DCS_NDRV_LSB 0
`define DCS_NDRV_MSB 1
`define DCS_SEL_INV_BIT 2
`define DCS_CLK_INV_BIT 3
`define DCS_PH_INV_BIT 4
`define DCS_FD_INV_BIT 5
`define DCS_DAC_INV_BIT 6
`define DCS_PER_DRV_BIT 7
`define DCS_DIV_LSB 8
`define DCS_DIV_MSB 15

// ==========================================================================
// Reset values, divider limits and driver count limits.
// ==========================================================================
`define DCS_DIV_RESET 8'h0F
`define DCS_DIV_MIN 8'h07
`define DCS_MIN_PERIOD_CLKS 10'h010
`define DCS_NDRV_RESET 2'h0
`define DCS_NDRV_BAD 2'h3
`define DCS_LAST_DRV_MAX 2'h2

// ==========================================================================
// Driver datagram layout, sent most significant bit first.
// ==========================================================================
`define DCS_DG_W 12
`define DCS_DG_MSB 11
`define DCS_BIT_TOP 4'hB
`define DCS_PH_MASK 12'h840
`define DCS_DAC_MASK 12'h7BC
`define DCS_FD_MASK 12'h002

`endif

// file: dcs_pkg.sv
`default_nettype none

package dcs_pkg;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'b00001,
        ST_LEAD = 5'b00010,
        ST_SHIFT = 5'b00100,
        ST_MARK = 5'b01000,
        ST_TAIL = 5'b10000
    } chain_state_t;

endpackage

`default_nettype wire

// file: dcs_pair_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module dcs_pair_buffer #(
    parameter int W = 12,
    parameter int DEPTH = 2
)
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Filling side.
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    // Draining side.
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    assign o_ready = (count_q != FULL);
    assign o_valid = (count_q != '0);
    assign o_data = mem_q[rd_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // ======================================================================
    // Storage and pointers.
    // ======================================================================
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == LAST) ? '0 : wr_q + AW'(1);
            end
            if (pop)
            begin
                rd_q <= (rd_q == LAST) ? '0 : rd_q + AW'(1);
            end
            if (push && !pop)
            begin
                count_q <= count_q + CW'(1);
            end
            else if (pop && !push)
            begin
                count_q <= count_q - CW'(1);
            end
        end
    end

endmodule

`default_nettype wire

// file: driver_chain_serial_config.sv
// What this block does
// [RQ1] Common select is active low with inversion clear, active high with it set.
// [RQ2] Serial clock pin is inverted when the clock inversion bit is set.
// [RQ3] Phase bits go out unchanged, or inverted when phase inversion is set.
// [RQ4] Fast decay bit is active high, or active low when its inversion is set.
// [RQ5] Current code bits go out normal, or inverted when their inversion is set.
// [RQ6] The inversion bits touch only the serial driver link, nothing else.
// [RQ7] Select mode picks one common select line or three per-driver lines.
// [RQ8] Software clears select inversion whenever per-driver select is chosen.
// [RQ9] Per-driver select lines are always active low.
// [RQ10] Divider is eight bits, meaningful range 7 to 255.
// [RQ11] Divider resets to 15.
// [RQ12] Serial clock is system clock over two times divider plus two.
// [RQ13] Below 7 the clock rate stays fixed and the duty cycle skews.
// [RQ14] Marker takes one serial clock at divider 7, one and a half above.
// [RQ15] Two-bit driver count field: 0, 1, 2 mean one to three drivers.
// [RQ16] Software should normally program divider 7 within the slowest driver limit.
// [RQ17] The global parameter register answers at absolute address 0x7E.
// [RQ18] With common select, one update shifts each driver word with its marker inside one select period.
// [RQ19] In per-driver mode only the current driver's select is asserted.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_consts.svh"

module driver_chain_serial_config #(
    parameter int BUF_DEPTH = 2
)
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Host datagram port.
    input wire logic i_host_valid,
    input wire logic [31:0] i_host_datagram,
    output logic o_host_rvalid,
    output logic [31:0] o_host_rdata,
    // Driver datagram stream.
    input wire logic i_dg_valid,
    output logic o_dg_ready,
    input wire logic [`DCS_DG_MSB:0] i_dg_data,
    // Driver chain pins.
    output logic o_chain_select_n,
    output logic o_driver2_select_n,
    output logic o_driver3_select_n,
    output logic o_chain_serial_clock,
    output logic o_chain_data,
    output logic o_next_motor_marker,
    output logic o_busy
);

    dcs_pkg::chain_state_t state_q;
    logic sel_inv_q;
    logic clk_inv_q;
    logic ph_inv_q;
    logic fd_inv_q;
    logic dac_inv_q;
    logic per_drv_q;
    logic [7:0] div_q;
    logic [1:0] ndrv_q;
    logic [`DCS_DG_MSB:0] shift_q;
    logic [9:0] cnt_q;
    logic [3:0] bit_q;
    logic [1:0] drv_q;
    logic sck_raw_q;
    logic mark_wait_q;
    logic buf_valid;
    logic [`DCS_DG_MSB:0] buf_data;
    logic take;
    logic host_hit;
    logic host_wr;
    logic host_rd;
    logic [9:0] hi_len;
    logic [9:0] lo_len;
    logic [9:0] mark_len;
    logic [1:0] last_idx;
    logic last_drv;
    logic sel_active;
    logic [`DCS_DG_MSB:0] inv_mask;
    logic [`DCS_DG_MSB:0] load_word;

    // ======================================================================
    // Host register access.
    // ======================================================================
    assign host_hit = ({i_host_datagram[`DCS_ADDR_MSB:`DCS_ADDR_LSB], 1'b0}
        == `DCS_GLOBAL_ABS_ADDR); // RQ17
    assign host_wr = i_host_valid && host_hit && !i_host_datagram[`DCS_RW_BIT];
    assign host_rd = i_host_valid && host_hit && i_host_datagram[`DCS_RW_BIT];

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sel_inv_q <= 1'b0;
            clk_inv_q <= 1'b0;
            ph_inv_q <= 1'b0;
            fd_inv_q <= 1'b0;
            dac_inv_q <= 1'b0;
            per_drv_q <= 1'b0;
            div_q <= `DCS_DIV_RESET; // RQ11
            ndrv_q <= `DCS_NDRV_RESET;
        end
        else if (host_wr)
        begin
            ndrv_q <= i_host_datagram[`DCS_NDRV_MSB:`DCS_NDRV_LSB];
            sel_inv_q <= i_host_datagram[`DCS_SEL_INV_BIT];
            clk_inv_q <= i_host_datagram[`DCS_CLK_INV_BIT];
            ph_inv_q <= i_host_datagram[`DCS_PH_INV_BIT];
            fd_inv_q <= i_host_datagram[`DCS_FD_INV_BIT];
            dac_inv_q <= i_host_datagram[`DCS_DAC_INV_BIT];
            per_drv_q <= i_host_datagram[`DCS_PER_DRV_BIT];
            div_q <= i_host_datagram[`DCS_DIV_MSB:`DCS_DIV_LSB]; // RQ10
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_host_rvalid <= 1'b0;
            o_host_rdata <= 32'h0000_0000;
        end
        else
        begin
            o_host_rvalid <= host_rd;
            if (host_rd)
            begin
                o_host_rdata <= {16'h0000, div_q, per_drv_q, dac_inv_q, fd_inv_q,
                    ph_inv_q, clk_inv_q, sel_inv_q, ndrv_q};
            end
        end
    end

    // ======================================================================
    // Timing derived from the divider.
    // ======================================================================
    assign hi_len = {2'b00, div_q} + 10'h001; // RQ12
    assign lo_len = (div_q < `DCS_DIV_MIN) ? (`DCS_MIN_PERIOD_CLKS - hi_len) : hi_len; // RQ13
    assign mark_len = (div_q <= `DCS_DIV_MIN) ? `DCS_MIN_PERIOD_CLKS
        : 10'(hi_len * 10'h003); // RQ14
    // The forbidden count is served as three drivers so the engine never runs away.
    assign last_idx = (ndrv_q == `DCS_NDRV_BAD) ? `DCS_LAST_DRV_MAX : ndrv_q; // RQ15
    assign last_drv = (drv_q == last_idx);

    // Inversion applies only to the serial datagram path.
    assign inv_mask = (ph_inv_q ? `DCS_PH_MASK : 12'h000)
        | (fd_inv_q ? `DCS_FD_MASK : 12'h000)
        | (dac_inv_q ? `DCS_DAC_MASK : 12'h000); // RQ3 RQ4 RQ5 RQ6
    assign load_word = buf_data ^ inv_mask;

    // ======================================================================
    // Two-entry word buffer.
    // ======================================================================
    assign take = (state_q == dcs_pkg::ST_IDLE)
        || ((state_q == dcs_pkg::ST_MARK) && mark_wait_q);

    dcs_pair_buffer #(
        .W(`DCS_DG_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_valid(i_dg_valid),
        .o_ready(o_dg_ready),
        .i_data(i_dg_data),
        .o_valid(buf_valid),
        .i_ready(take),
        .o_data(buf_data)
    );

    // ======================================================================
    // Chain update engine.
    // ======================================================================
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q <= dcs_pkg::ST_IDLE;
            shift_q <= 12'h000;
            cnt_q <= 10'h000;
            bit_q <= 4'h0;
            drv_q <= 2'h0;
            sck_raw_q <= 1'b0;
            mark_wait_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                dcs_pkg::ST_IDLE:
                begin
                    if (buf_valid)
                    begin
                        shift_q <= load_word;
                        drv_q <= 2'h0;
                        cnt_q <= hi_len - 10'h001;
                        state_q <= dcs_pkg::ST_LEAD; // RQ18
                    end
                end
                dcs_pkg::ST_LEAD:
                begin
                    if (cnt_q == 10'h000)
                    begin
                        bit_q <= `DCS_BIT_TOP;
                        sck_raw_q <= 1'b0;
                        cnt_q <= lo_len - 10'h001;
                        state_q <= dcs_pkg::ST_SHIFT;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 10'h001;
                    end
                end
                dcs_pkg::ST_SHIFT:
                begin
                    if (cnt_q != 10'h000)
                    begin
                        cnt_q <= cnt_q - 10'h001;
                    end
                    else if (!sck_raw_q)
                    begin
                        sck_raw_q <= 1'b1;
                        cnt_q <= hi_len - 10'h001; // RQ12
                    end
                    else
                    begin
                        sck_raw_q <= 1'b0;
                        if (bit_q == 4'h0)
                        begin
                            mark_wait_q <= 1'b0;
                            cnt_q <= mark_len - 10'h001; // RQ14
                            state_q <= dcs_pkg::ST_MARK;
                        end
                        else
                        begin
                            bit_q <= bit_q - 4'h1;
                            shift_q <= {shift_q[`DCS_DG_MSB-1:0], 1'b0};
                            cnt_q <= lo_len - 10'h001; // RQ13
                        end
                    end
                end
                dcs_pkg::ST_MARK:
                begin
                    if (mark_wait_q)
                    begin
                        if (buf_valid)
                        begin
                            mark_wait_q <= 1'b0;
                            shift_q <= load_word;
                            drv_q <= drv_q + 2'h1;
                            bit_q <= `DCS_BIT_TOP;
                            cnt_q <= lo_len - 10'h001;
                            state_q <= dcs_pkg::ST_SHIFT; // RQ18
                        end
                    end
                    else if (cnt_q != 10'h000)
                    begin
                        cnt_q <= cnt_q - 10'h001;
                    end
                    else if (last_drv)
                    begin
                        cnt_q <= hi_len - 10'h001;
                        state_q <= dcs_pkg::ST_TAIL; // RQ15
                    end
                    else
                    begin
                        mark_wait_q <= 1'b1;
                    end
                end
                dcs_pkg::ST_TAIL:
                begin
                    if (cnt_q == 10'h000)
                    begin
                        state_q <= dcs_pkg::ST_IDLE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 10'h001;
                    end
                end
                default:
                begin
                    state_q <= dcs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // Pin registers.
    // ======================================================================
    assign sel_active = (state_q != dcs_pkg::ST_IDLE);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_chain_select_n <= 1'b1;
            o_driver2_select_n <= 1'b1;
            o_driver3_select_n <= 1'b1;
            o_chain_serial_clock <= 1'b0;
            o_chain_data <= 1'b0;
            o_next_motor_marker <= 1'b0;
            o_busy <= 1'b0;
        end
        else
        begin
            if (per_drv_q)
            begin
                o_chain_select_n <= !(sel_active && (drv_q == 2'h0)); // RQ7 RQ9 RQ19
                o_driver2_select_n <= !(sel_active && (drv_q == 2'h1)); // RQ9 RQ19
                o_driver3_select_n <= !(sel_active && (drv_q == 2'h2)); // RQ9 RQ19
            end
            else
            begin
                o_chain_select_n <= sel_inv_q ? sel_active : !sel_active; // RQ1 RQ7
                o_driver2_select_n <= 1'b1;
                o_driver3_select_n <= 1'b1;
            end
            o_chain_serial_clock <= sck_raw_q ^ clk_inv_q; // RQ2
            o_chain_data <= shift_q[`DCS_DG_MSB];
            o_next_motor_marker <= (state_q == dcs_pkg::ST_MARK) && !mark_wait_q; // RQ14
            o_busy <= sel_active;
        end
    end

    // ======================================================================
    // Checks.
    // ======================================================================
    logic [9:0] hi_run_q;
    logic [9:0] lo_run_q;
    logic [9:0] mk_run_q;
    logic [1:0] mk_cnt_q;
    logic host_seen_q;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            hi_run_q <= 10'h000;
            lo_run_q <= 10'h000;
            mk_run_q <= 10'h000;
            mk_cnt_q <= 2'h0;
            host_seen_q <= 1'b0;
        end
        else
        begin
            hi_run_q <= sck_raw_q ? hi_run_q + 10'h001 : 10'h000;
            lo_run_q <= (state_q == dcs_pkg::ST_SHIFT && !sck_raw_q)
                ? lo_run_q + 10'h001 : 10'h000;
            mk_run_q <= (state_q == dcs_pkg::ST_MARK && !mark_wait_q)
                ? mk_run_q + 10'h001 : 10'h000;
            if (state_q == dcs_pkg::ST_IDLE)
            begin
                mk_cnt_q <= 2'h0;
            end
            else if (state_q == dcs_pkg::ST_SHIFT && cnt_q == 10'h000 && sck_raw_q
                && bit_q == 4'h0)
            begin
                mk_cnt_q <= mk_cnt_q + 2'h1;
            end
            host_seen_q <= host_seen_q || host_wr;
        end
    end

    AST_DIV_RESET: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ11
        !host_seen_q |-> div_q == `DCS_DIV_RESET)
        else $error("divider left its reset value without a write");

    AST_COMMON_SELECT_LEVEL: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ1
        (!per_drv_q && !host_wr) |=> o_chain_select_n == ($past(sel_inv_q)
        ? $past(sel_active) : !$past(sel_active)))
        else $error("common select level does not follow its polarity");

    AST_CLOCK_POLARITY: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ2
        (state_q == dcs_pkg::ST_IDLE && !host_wr) ##1 (state_q == dcs_pkg::ST_IDLE)
        |-> o_chain_serial_clock == clk_inv_q)
        else $error("idle serial clock level ignores the inversion bit");

    AST_PHASE_FIRST_BIT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ3
        (state_q == dcs_pkg::ST_IDLE && buf_valid)
        |-> ##2 o_chain_data == ($past(buf_data[`DCS_DG_MSB], 2) ^ $past(ph_inv_q, 2)))
        else $error("first phase bit not sent with its polarity");

    AST_PER_DRIVER_ONE_LOW: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ19
        $past(per_drv_q) |-> $countones({o_chain_select_n, o_driver2_select_n,
        o_driver3_select_n}) >= 2)
        else $error("more than one per-driver select asserted");

    AST_CLOCK_HIGH_HALF: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ12
        ($fell(sck_raw_q) && $stable(div_q)) |-> $past(hi_run_q) + 10'h001 == hi_len)
        else $error("serial clock high half has the wrong length");

    AST_CLOCK_LOW_HALF: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ13
        ($rose(sck_raw_q) && $stable(div_q)) |-> $past(lo_run_q) + 10'h001 == lo_len)
        else $error("serial clock low half has the wrong length");

    AST_MARKER_LENGTH: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ14
        (state_q == dcs_pkg::ST_MARK && !mark_wait_q && cnt_q == 10'h000 && $stable(div_q))
        |-> mk_run_q + 10'h001 == mark_len)
        else $error("marker period has the wrong length");

    AST_DRIVER_COUNT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ15
        (state_q == dcs_pkg::ST_TAIL && $past(state_q) == dcs_pkg::ST_MARK)
        |-> mk_cnt_q == last_idx + 2'h1)
        else $error("update did not carry one word per configured driver");

    AST_HOST_READBACK: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ17
        host_rd |=> o_host_rvalid && o_host_rdata[`DCS_DIV_MSB:`DCS_DIV_LSB] == $past(div_q))
        else $error("register read did not return the divider");

    COV_THREE_DRIVERS: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        state_q == dcs_pkg::ST_TAIL && mk_cnt_q == 2'h3);
    COV_PER_DRIVER_THIRD: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        per_drv_q && !o_driver3_select_n);
    COV_SKEWED_CLOCK: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        div_q < `DCS_DIV_MIN && $rose(sck_raw_q));
    COV_BUFFER_FULL: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        !o_dg_ready && i_dg_valid);

endmodule

`default_nettype wire

// file: chain_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Driver chain receiver.
module chain_partner
(
    // Clock, reset and clock polarity.
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_inv,
    // Chain pins.
    input wire logic i_sck,
    input wire logic i_data,
    input wire logic i_mark,
    input wire logic [2:0] i_sel_n,
    // Received word and timing.
    output logic o_got,
    output logic [11:0] o_word,
    output logic [2:0] o_sel,
    output int o_hi,
    output int o_lo,
    output int o_mark
);
    logic sck_q;
    logic mark_q;
    logic [11:0] sh;
    int hi_n;
    int lo_n;
    int mk_n;
    wire logic sck = i_sck ^ i_clk_inv;
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            {sck_q, mark_q, sh, o_got, o_word, o_sel} <= '0;
            {hi_n, lo_n, mk_n, o_hi, o_lo, o_mark} <= '0;
        end
        else
        begin
            sck_q <= sck;
            mark_q <= i_mark;
            o_got <= 1'b0;
            hi_n <= sck ? hi_n + 1 : 0;
            lo_n <= sck ? 0 : lo_n + 1;
            mk_n <= i_mark ? mk_n + 1 : 0;
            if (sck && !sck_q)
            begin
                sh <= {sh[10:0], i_data};
                o_lo <= lo_n;
            end
            if (!sck && sck_q)
                o_hi <= hi_n;
            if (i_mark && !mark_q)
                o_sel <= i_sel_n;
            if (!i_mark && mark_q)
            begin
                o_got <= 1'b1;
                o_word <= sh;
                o_mark <= mk_n;
            end
        end
    end
endmodule
`default_nettype wire

// file: driver_chain_serial_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Chain configuration bench.
module driver_chain_serial_config_bench;
    logic i_clk, i_reset_n, i_host_valid, i_dg_valid, got;
    logic [31:0] i_host_datagram, o_host_rdata, v;
    logic [11:0] i_dg_data, word, m;
    logic o_host_rvalid, o_dg_ready, o_chain_select_n, o_driver2_select_n, o_driver3_select_n;
    logic o_chain_serial_clock, o_chain_data, o_next_motor_marker, o_busy;
    logic [15:0] cfg;
    logic [2:0] sel, xs;
    logic [15:0] cfgs [5] = '{16'h0F00, 16'h077E, 16'h08A1, 16'h03D2, 16'hFF48};
    int fails, checked, hi, lo, mk, h, idx, n;
    logic [11:0] q [$];
    driver_chain_serial_config dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_host_valid(i_host_valid), .i_host_datagram(i_host_datagram),
        .o_host_rvalid(o_host_rvalid), .o_host_rdata(o_host_rdata), .i_dg_valid(i_dg_valid),
        .o_dg_ready(o_dg_ready), .i_dg_data(i_dg_data), .o_chain_select_n(o_chain_select_n),
        .o_driver2_select_n(o_driver2_select_n), .o_driver3_select_n(o_driver3_select_n),
        .o_chain_serial_clock(o_chain_serial_clock), .o_chain_data(o_chain_data),
        .o_next_motor_marker(o_next_motor_marker), .o_busy(o_busy));
    chain_partner link (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_inv(cfg[3]),
        .i_sck(o_chain_serial_clock), .i_data(o_chain_data), .i_mark(o_next_motor_marker),
        .i_sel_n({o_driver3_select_n, o_driver2_select_n, o_chain_select_n}), .o_got(got),
        .o_word(word), .o_sel(sel), .o_hi(hi), .o_lo(lo), .o_mark(mk));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task wr(input logic [7:0] top, input logic [15:0] d);
        @(posedge i_clk);
        i_host_valid <= 1'b1;
        i_host_datagram <= {top, 8'h00, d};
        @(posedge i_clk);
        i_host_valid <= 1'b0;
    endtask
    task rd(input logic [7:0] top, input logic ok, output logic [31:0] r);
        @(posedge i_clk);
        i_host_valid <= 1'b1;
        i_host_datagram <= {top, 24'h0};
        @(posedge i_clk);
        i_host_valid <= 1'b0;
        #1 chk(32'(o_host_rvalid), 32'(ok));
        r = o_host_rdata;
    endtask
    task push(input logic [11:0] w);
        @(posedge i_clk);
        i_dg_valid <= 1'b1;
        i_dg_data <= w;
        q.push_back(w ^ m);
        for (int t = 0; t < 20000; t++)
        begin
            @(posedge i_clk);
            if (o_dg_ready === 1'b1)
                break;
        end
        if (o_dg_ready !== 1'b1) fails++;
        i_dg_valid <= 1'b0;
        i_dg_data <= ~w;
    endtask
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    initial
    begin
        #400000;
        fails++;
        wrap_up;
    end
    always @(posedge i_clk)
    begin
        if (got === 1'b1)
        begin
            h = cfg[15:8] + 1;
            chk(32'(word), 32'(q.pop_front()));
            xs = cfg[7] ? ~(3'b1 << idx) : {2'b11, cfg[2]};
            chk(32'(sel), 32'(xs));
            chk(32'(o_busy), 32'h1);
            chk(hi, h);
            chk(lo, cfg[15:8] >= 7 ? h : 16 - h);
            chk(mk, cfg[15:8] <= 7 ? 16 : 3 * h);
            idx = idx == cfg[1:0] ? 0 : idx + 1;
        end
    end
    initial
    begin
        {i_reset_n, i_host_valid, i_dg_valid, i_host_datagram, i_dg_data, cfg, m} = '0;
        void'($urandom(32'h884C));
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(8'h7F, 1'b1, v);
        chk(v, 32'h0F00);
        for (int i = 0; i < 6; i++)
        begin
            n = $urandom % 1000;
            cfg = i < 5 ? cfgs[i] : {8'(7 + n % 24), n[7:3], n[7] ? 1'b0 : n[2], 2'(n % 3)};
            wr(8'h7E, cfg);
            wr(8'h7C, ~cfg);
            rd(8'h7D, 1'b0, v);
            rd(8'h7F, 1'b1, v);
            chk(v, 32'(cfg));
            idx = 0;
            m = (cfg[4] ? 12'h840 : 12'h0) | (cfg[6] ? 12'h7BC : 12'h0) | (cfg[5] ? 12'h002 : 12'h0);
            for (int k = 0; k <= cfg[1:0]; k++)
                push(12'($urandom));
            #1 if (cfg[1:0] == 2'h2) chk(32'(o_dg_ready), 32'h0);
            n = 0;
            while ((q.size() > 0 || o_busy !== 1'b0) && n < 40000)
            begin
                @(posedge i_clk);
                n++;
            end
            if (n >= 40000) fails++;
            repeat (2) @(posedge i_clk);
            #1 chk(32'(o_chain_serial_clock), 32'(cfg[3]));
            chk(32'(o_chain_select_n), 32'(!cfg[2]));
        end
        wrap_up;
    end
endmodule
`default_nettype wire
